/* File: verilog/rotdec_top.sv */
// Rotary encoder decoder: switch history, sequence matching, step pulses

// What this block does
// - Outside setting 4, each change of the two switch inputs still present in IDLE is written into a cyclic history.
// - After each recorded change from the third on, the three newest states are checked for a step.
// - Four three-state sequences per direction exist in one switch cycle.
// - Settings 2 or 3 watch one sequence pair: one step per cycle.
// - Setting 1 watches two sequence pairs: two steps per cycle.
// - Setting 5 gives finest resolution, 1 middle, 2 or 3 coarsest.
// - Setting 4 treats inputs as Up and Down keys, one step per press.
// - Only full monotonic sequences count, so bounce cannot alternate steps.
module rotdec_top (
   input  wire logic       ref_clk_in,
   input  wire logic       reset_n_in,
   input  wire logic [1:0] sw_in,
   input  wire logic [2:0] setting_in,
   output logic            step_up_out,
   output logic            step_down_out
);
   import rotdec_pkg::*;

   // =====================================================================
   // Helpers
   // =====================================================================
   // Position of a state in the forward Gray cycle
   function automatic logic [1:0] gray_pos(input logic [1:0] s);
      case (s)
         2'h0: gray_pos = 2'h0;
         2'h1: gray_pos = 2'h1;
         2'h3: gray_pos = 2'h2;
         default: gray_pos = 2'h3;
      endcase
   endfunction : gray_pos

   // Whether a sequence ending at this position is watched by the setting
   function automatic logic watched(input logic [2:0] set, input logic [1:0] pos);
      case (set)
         ROTDEC_SET_FINE:  watched = 1'b1;
         ROTDEC_SET_MID:   watched = (pos[0] == 1'b0);
         ROTDEC_SET_LOW_A,
         ROTDEC_SET_LOW_B: watched = (pos == 2'h0);
         default:          watched = 1'b0;
      endcase
   endfunction : watched

   // =====================================================================
   // State
   // =====================================================================
   rotdec_phase_e         phase_ff,  nxt_phase;
   logic [1:0]            last_ff,   nxt_last;
   logic [1:0]            prev_ff,   nxt_prev;
   logic [1:0]            fill_ff,   nxt_fill;
   logic [ROTDEC_PTR_W-1:0] wptr_ff, nxt_wptr;
   logic [1:0]            key_ff,    nxt_key;
   rotdec_step_s          step_ff,   nxt_step;
   logic                  hist_we;
   logic [ROTDEC_PTR_W-1:0] rptr;
   logic [1:0]            oldest;
   logic [1:0]            p0, p1, p2;
   logic                  fwd, rev;
   logic                  keys;

   assign keys = (setting_in == ROTDEC_SET_KEYS);

   rotdec_hist u_hist (
      .ref_clk_in  (ref_clk_in),
      .reset_n_in  (reset_n_in),
      .wr_en_in    (hist_we),
      .wr_ptr_in   (wptr_ff),
      .wr_data_in  (sw_in),
      .rd_ptr_in   (rptr),
      .rd_data_out (oldest)
   );

   // Read slot two behind the newest write, valid one cycle later in EVAL
   assign rptr = wptr_ff - 2'h3;

   // =====================================================================
   // Sequence match
   // =====================================================================
   // gray order
   always_comb begin
      p0 = gray_pos(oldest);
      p1 = gray_pos(prev_ff);
      p2 = gray_pos(last_ff);
   end

   always_comb begin
      fwd = (p1 == p0 + 2'h1) && (p2 == p1 + 2'h1);
      rev = (p1 == p0 - 2'h1) && (p2 == p1 - 2'h1);
   end

   // =====================================================================
   // Next state
   // =====================================================================
   always_comb begin
      nxt_phase = phase_ff;
      nxt_last  = last_ff;
      nxt_prev  = prev_ff;
      nxt_fill  = fill_ff;
      nxt_wptr  = wptr_ff;
      nxt_key   = sw_in;
      nxt_step  = '0;
      hist_we   = 1'b0;
      if (keys) begin
         nxt_step.up   = sw_in[0] & ~key_ff[0];
         nxt_step.down = sw_in[1] & ~key_ff[1];
         nxt_phase     = ROTDEC_IDLE;
         nxt_last      = sw_in;
      end else begin
         case (phase_ff)
            ROTDEC_IDLE: begin
               if (sw_in != last_ff) begin
                  hist_we   = 1'b1;
                  nxt_wptr  = wptr_ff + 2'h1;
                  nxt_prev  = last_ff;
                  nxt_last  = sw_in;
                  nxt_phase = ROTDEC_RECORD;
                  if (fill_ff != ROTDEC_FILL_FULL) begin
                     nxt_fill = fill_ff + 2'h1;
                  end
               end
            end
            ROTDEC_RECORD: begin
               nxt_phase = ROTDEC_EVAL;
            end
            ROTDEC_EVAL: begin
               if (fill_ff == ROTDEC_FILL_FULL) begin
                  nxt_step.up   = fwd && watched(setting_in, p2);
                  nxt_step.down = rev && watched(setting_in, p2);
               end
               nxt_phase = ROTDEC_IDLE;
            end
            default: nxt_phase = ROTDEC_IDLE;
         endcase
      end
   end

   // Changes arriving during RECORD/EVAL are picked up in IDLE next
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         phase_ff <= ROTDEC_IDLE;
         last_ff  <= ROTDEC_STATE_RST;
         prev_ff  <= ROTDEC_STATE_RST;
         fill_ff  <= ROTDEC_FILL_RST;
         wptr_ff  <= ROTDEC_PTR_RST;
         key_ff   <= ROTDEC_STATE_RST;
         step_ff  <= '0;
      end else begin
         phase_ff <= nxt_phase;
         last_ff  <= nxt_last;
         prev_ff  <= nxt_prev;
         fill_ff  <= nxt_fill;
         wptr_ff  <= nxt_wptr;
         key_ff   <= nxt_key;
         step_ff  <= nxt_step;
      end
   end

   assign step_up_out   = step_ff.up;
   assign step_down_out = step_ff.down;

   // =====================================================================
   // Assertions
   // =====================================================================
   sequence s_change;
      !keys && phase_ff == ROTDEC_IDLE && sw_in != last_ff;
   endsequence

   property p_record;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      s_change |=> last_ff == $past(sw_in) && phase_ff == ROTDEC_RECORD;
   endproperty
   a_record: assert property (p_record) else $error("change not recorded");

   property p_eval_after;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      s_change |=> ##1 phase_ff == ROTDEC_EVAL;
   endproperty
   a_eval_after: assert property (p_eval_after) else $error("no evaluation");

   property p_no_both;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      !(step_up_out && step_down_out) || keys;
   endproperty
   a_no_both: assert property (p_no_both) else $error("both directions");

   property p_step_src;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      (step_up_out || step_down_out) && !keys && !$past(keys) |->
         $past(phase_ff) == ROTDEC_EVAL;
   endproperty
   a_step_src: assert property (p_step_src) else $error("stray step");

   property p_coarse;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      phase_ff == ROTDEC_EVAL && (setting_in == ROTDEC_SET_LOW_A ||
         setting_in == ROTDEC_SET_LOW_B) && p2 != 2'h0 |=> !step_up_out && !step_down_out;
   endproperty
   a_coarse: assert property (p_coarse) else $error("coarse extra step");

   property p_mid;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      phase_ff == ROTDEC_EVAL && setting_in == ROTDEC_SET_MID && p2[0]
         |=> !step_up_out && !step_down_out;
   endproperty
   a_mid: assert property (p_mid) else $error("mid extra step");

   property p_fine;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      phase_ff == ROTDEC_EVAL && setting_in == ROTDEC_SET_FINE &&
         fill_ff == ROTDEC_FILL_FULL && fwd |=> step_up_out;
   endproperty
   a_fine: assert property (p_fine) else $error("fine step lost");

   property p_key;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      keys && sw_in[0] && !key_ff[0] |=> step_up_out;
   endproperty
   a_key: assert property (p_key) else $error("key press lost");

   property p_dir;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      phase_ff == ROTDEC_EVAL && !keys && rev |=> !step_up_out;
   endproperty
   a_dir: assert property (p_dir) else $error("wrong direction");

endmodule : rotdec_top

/* File: verilog/rotdec_pkg.sv */
// Package of constants and types for the rotary encoder decoder
package rotdec_pkg;

   // =====================================================================
   // Decode settings
   // =====================================================================
   localparam logic [2:0] ROTDEC_SET_MID    = 3'h1;
   localparam logic [2:0] ROTDEC_SET_LOW_A  = 3'h2;
   localparam logic [2:0] ROTDEC_SET_LOW_B  = 3'h3;
   localparam logic [2:0] ROTDEC_SET_KEYS   = 3'h4;
   localparam logic [2:0] ROTDEC_SET_FINE   = 3'h5;

   // =====================================================================
   // History and reset values
   // =====================================================================
   localparam int         ROTDEC_HIST_DEPTH = 4;
   localparam int         ROTDEC_PTR_W      = 2;
   localparam logic [1:0] ROTDEC_STATE_RST  = 2'h0;
   localparam logic [1:0] ROTDEC_PTR_RST    = 2'h0;
   localparam logic [1:0] ROTDEC_FILL_RST   = 2'h0;
   localparam logic [1:0] ROTDEC_FILL_FULL  = 2'h3;

   // Step request carried from decoder to outputs
   typedef struct packed {
      logic up;
      logic down;
   } rotdec_step_s;

   // Decoder phases
   typedef enum logic [2:0] {
      ROTDEC_IDLE   = 3'b001,
      ROTDEC_RECORD = 3'b010,
      ROTDEC_EVAL   = 3'b100
   } rotdec_phase_e;

endpackage : rotdec_pkg

/* File: verilog/rotdec_hist.sv */
// Small cyclic memory holding the recent switch states
module rotdec_hist (
   input  wire logic                            ref_clk_in,
   input  wire logic                            reset_n_in,
   input  wire logic                            wr_en_in,
   input  wire logic [rotdec_pkg::ROTDEC_PTR_W-1:0] wr_ptr_in,
   input  wire logic [1:0]                      wr_data_in,
   input  wire logic [rotdec_pkg::ROTDEC_PTR_W-1:0] rd_ptr_in,
   output logic      [1:0]                      rd_data_out
);
   import rotdec_pkg::*;

   logic [1:0] mem_ff [ROTDEC_HIST_DEPTH];
   logic [1:0] rd_ff;

   // =====================================================================
   // Storage and registered read port
   // =====================================================================
   // Read returns old data on same address; reader always looks at older slots
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         for (int i = 0; i < ROTDEC_HIST_DEPTH; i++) begin
            mem_ff[i] <= ROTDEC_STATE_RST;
         end
         rd_ff <= ROTDEC_STATE_RST;
      end else begin
         if (wr_en_in) begin
            mem_ff[wr_ptr_in] <= wr_data_in;
         end
         rd_ff <= mem_ff[rd_ptr_in];
      end
   end

   assign rd_data_out = rd_ff;

endmodule : rotdec_hist

/* File: dv/rotdec_enc_model.sv */
// Partner model: rotary encoder contacts or two push keys
module rotdec_enc_model (
   input  wire logic       ref_clk_in,
   input  wire logic       reset_n_in,
   input  wire logic       move_in,
   input  wire logic       dir_up_in,
   input  wire logic       key_mode_in,
   input  wire logic [1:0] key_in,
   output logic      [1:0] sw_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // =====================================================================
   // Shaft position
   // =====================================================================
   logic [1:0] pos_ff;

   // Shaft moves one Gray position per request; reset parks it at 00
   always @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         pos_ff <= 2'h0;
      end else if (move_in) begin
         pos_ff <= dir_up_in ? pos_ff + 2'h1 : pos_ff - 2'h1;
      end
   end

   // Keys drive the contacts directly, the shaft shows Gray code
   assign sw_out = key_mode_in ? key_in : {pos_ff[1], pos_ff[1] ^ pos_ff[0]};
endmodule : rotdec_enc_model

/* File: dv/tb_top.sv */
// Self-checking bench for the rotary encoder decoder
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import rotdec_pkg::*;

   // =====================================================================
   // Signals and counters
   // =====================================================================
   logic       ref_clk_in = 1'b0;
   logic       reset_n_in = 1'b0;
   logic       move       = 1'b0;
   logic       dir_up     = 1'b0;
   logic       key_mode   = 1'b0;
   logic [1:0] key        = 2'h0;
   logic [2:0] setting    = 3'h5;
   logic [1:0] sw;
   logic       step_up;
   logic       step_down;
   int         errors, compares, exp_up, exp_dn, got_up, got_dn;
   int         hist[$];

   always #2 ref_clk_in = ~ref_clk_in;

   // Count pulses; an unknown pulse never counts
   always @(posedge ref_clk_in) begin
      if (step_up === 1'b1) got_up++;
      if (step_down === 1'b1) got_dn++;
   end

   rotdec_enc_model u_enc (
      .ref_clk_in (ref_clk_in),
      .reset_n_in (reset_n_in),
      .move_in    (move),
      .dir_up_in  (dir_up),
      .key_mode_in(key_mode),
      .key_in     (key),
      .sw_out     (sw)
   );

   rotdec_top DUT (
      .ref_clk_in   (ref_clk_in),
      .reset_n_in   (reset_n_in),
      .sw_in        (sw),
      .setting_in   (setting),
      .step_up_out  (step_up),
      .step_down_out(step_down)
   );

   // =====================================================================
   // Tasks
   // =====================================================================
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask : tick

   task automatic check(input string what, input int e, input int g);
      compares++;
      if (e !== g) begin
         errors++;
         $display("unexpected %s expected %0d seen %0d", what, e, g);
      end
   endtask : check

   task automatic close_out;
      $display("TB: errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out

   // Setting is static, so every setting starts from a fresh reset
   task automatic do_reset(input logic [2:0] s);
      reset_n_in <= 1'b0;
      setting    <= s;
      key_mode   <= (s == ROTDEC_SET_KEYS);
      key        <= 2'h0;
      tick(2);
      reset_n_in <= 1'b1;
      tick(3);
      hist.delete();
      exp_up = 0;
      exp_dn = 0;
      got_up = 0;
      got_dn = 0;
   endtask : do_reset

   // Which end positions count for the present setting
   function automatic int counts_at(input int p);
      case (setting)
         ROTDEC_SET_FINE:                   return 1;
         ROTDEC_SET_MID:                    return int'(p % 2 == 0);
         ROTDEC_SET_LOW_A, ROTDEC_SET_LOW_B: return int'(p == 0);
         default:                           return 0;
      endcase
   endfunction : counts_at

   // One detent move, then the reference model judges the newest triple
   task automatic turn(input bit up);
      int n;
      int p;
      move   <= 1'b1;
      dir_up <= up;
      tick(1);
      move   <= 1'b0;
      p = ((hist.size() > 0 ? hist[$] : 0) + (up ? 1 : 3)) % 4;
      hist.push_back(p);
      n = hist.size();
      // The third recorded change is the first judged; only monotonic triples count
      if (n >= 3 && hist[n-2] == (hist[n-3] + 1) % 4 && p == (hist[n-2] + 1) % 4)
         exp_up += counts_at(p);
      if (n >= 3 && hist[n-2] == (hist[n-3] + 3) % 4 && p == (hist[n-2] + 3) % 4)
         exp_dn += counts_at(p);
      tick(6);
      check("up steps", exp_up, got_up);
      check("down steps", exp_dn, got_dn);
   endtask : turn

   // =====================================================================
   // Main sequence
   // =====================================================================
   initial begin
      logic [2:0] sets[6];
      logic [1:0] k;
      int         seed;
      sets = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h0, 3'h6};
      seed = $urandom(32'he958);
      foreach (sets[i]) begin
         do_reset(sets[i]);
         for (int d = 0; d < 2; d++) begin
            for (int j = 0; j < 24; j++) begin
               turn((($urandom % 4) != 0) ^ d[0]);
            end
         end
         $display("test setting %0d done", sets[i]);
      end
      do_reset(ROTDEC_SET_KEYS);
      for (int j = 0; j < 12; j++) begin
         k = 2'($urandom % 3 + 1);
         key <= k;
         tick(3);
         key <= 2'h0;
         tick(3);
         exp_up += k[0];
         exp_dn += k[1];
         check("key up steps", exp_up, got_up);
         check("key down steps", exp_dn, got_dn);
      end
      $display("test key mode done");
      close_out();
   end

   // Cuts a hang short
   initial begin
      #100000;
      errors++;
      close_out();
   end
endmodule : tb_top
